/* File: verilog/rss_sequencer.sv */
/*
 * Start-up sequencer and current report of a multiphase regulator
 * controller, with its decoded command port.
 * Assumes a command layer outside that decodes the serial host bus,
 * analog comparators that give the pin levels, and a current converter
 * on ref_clk that gives current_monitor_code.
 */
// What this block does
// - In shutdown all phase PWM outputs are held high impedance.
// - Stay shut down until the sequencing enable comparator reports high.
// - Run only while the thermal-monitor enable is above its threshold.
// - Early thermal alert sets status and alert; clear-fault command releases both.
// - Ramp to boot, hold, then regulate to a valid target; off code stays down.
// - Wait for configuration bank load or the CFG_LOAD_CYCLES timeout, then fixed 20 us delay before ramping.
// - Hold boot until host sends a target; valid target starts second ramp.
// - A valid target during the boot ramp redirects the ramp at once.
// - Both ramps move the DAC in 5 mV steps paced by the slew setting.
// - Sample current monitor every 88 us into the current readback register.
// - At 2.5 V or more reading saturates at maximum current, alert asserted.
// - Add the programmable and calibration offsets to the current reading.
// - Current monitor above 3.0 V forces overcurrent shutdown.
// - Ready goes high only after soft-start and with output in window.
// - A 5-bit slew field picks one of sixteen rates for both ramps.
`timescale 1ns/1ps
`include "rss_cfg.svh"
module rss_sequencer
    import rss_pkg::*;
#(
    parameter logic [18:0] CFG_LOAD_CYCLES = 19'(`RSS_CFG_LOAD_CYC)
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic supply_por_ok,
    input wire logic power_sequence_enable,
    input wire logic thermal_monitor_enable,
    input wire logic thermal_alert,
    input wire logic configuration_bank_loaded,
    input wire logic output_in_window,
    input wire logic current_monitor_out_over_ocp,
    input wire logic [9:0] current_monitor_code,
    input wire logic [7:0] boot_voltage_setting,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] cmd_rdata,
    output logic cmd_rvalid,
    input wire logic host_alert_n_in,
    output logic host_alert_n_out,
    output logic host_alert_n_oe,
    output logic pwm_hiz,
    output logic [7:0] dac_code,
    output logic regulator_ready
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [6:0] pins_sync;
    logic por_s;
    logic en_s;
    logic tm_s;
    logic talert_s;
    logic bank_s;
    logic win_s;
    logic ocp_s;

    rss_sync #(.WIDTH(7)) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin_in({supply_por_ok, power_sequence_enable, thermal_monitor_enable,
            thermal_alert, configuration_bank_loaded, output_in_window,
            current_monitor_out_over_ocp}),
        .pin_sync(pins_sync)
    );

    assign {por_s, en_s, tm_s, talert_s, bank_s, win_s, ocp_s} = pins_sync;

    // ------------------------------------------------------------------
    // Ramp engine
    // ------------------------------------------------------------------
    rss_top_s st_reg;
    rss_top_s st_next;
    logic ramp_run;
    logic [7:0] ramp_target;
    logic [8:0] step_cycles;
    logic [7:0] dac_now;

    // Ramp runs from the boot ramp onward, aimed at boot or host target
    always_comb
    begin
        ramp_run = (st_reg.state != RSS_SHUTDOWN) &&
            (st_reg.state != RSS_CFG_LOAD) &&
            (st_reg.state != RSS_FIXED_DELAY);
        if ((st_reg.state == RSS_TARGET_RAMP) || (st_reg.state == RSS_REGULATE))
            ramp_target = st_reg.target;
        else
            ramp_target = boot_voltage_setting;
    end

    // Step period from slew field; top bit of field ignored
    always_comb
    begin
        unique case (st_reg.slew[3:0])
            4'h0: step_cycles = 9'(`RSS_STEP_CYC(`RSS_SLEW_0));
            4'h1: step_cycles = 9'(`RSS_STEP_CYC(`RSS_SLEW_1));
            4'h2: step_cycles = 9'(`RSS_STEP_CYC(`RSS_SLEW_2));
            4'h3: step_cycles = 9'(`RSS_STEP_CYC(`RSS_SLEW_3));
            4'h4: step_cycles = 9'(`RSS_STEP_CYC(`RSS_SLEW_4));
            4'h5: step_cycles = 9'(`RSS_STEP_CYC(`RSS_SLEW_5));
            4'h6: step_cycles = 9'(`RSS_STEP_CYC(`RSS_SLEW_6));
            4'h7: step_cycles = 9'(`RSS_STEP_CYC(`RSS_SLEW_7));
            4'h8: step_cycles = 9'(`RSS_STEP_CYC(`RSS_SLEW_8));
            4'h9: step_cycles = 9'(`RSS_STEP_CYC(`RSS_SLEW_9));
            4'hA: step_cycles = 9'(`RSS_STEP_CYC(`RSS_SLEW_A));
            4'hB: step_cycles = 9'(`RSS_STEP_CYC(`RSS_SLEW_B));
            4'hC: step_cycles = 9'(`RSS_STEP_CYC(`RSS_SLEW_C));
            4'hD: step_cycles = 9'(`RSS_STEP_CYC(`RSS_SLEW_D));
            4'hE: step_cycles = 9'(`RSS_STEP_CYC(`RSS_SLEW_E));
            4'hF: step_cycles = 9'(`RSS_STEP_CYC(`RSS_SLEW_F));
        endcase
    end

    rss_ramp u_ramp (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ramp_run(ramp_run),
        .ramp_target(ramp_target),
        .step_cycles(step_cycles),
        .dac_code(dac_now)
    );

    // ------------------------------------------------------------------
    // Sequencer, registers and current report
    // ------------------------------------------------------------------
    logic start_ok;
    logic wr;
    logic rd;
    logic set_cmd;
    logic clr_fault;
    logic sat;
    logic [15:0] raw_iout;
    logic [7:0] st_set;

    always_comb
    begin
        st_next = st_reg;
        wr = cmd_valid && cmd_write;
        rd = cmd_valid && !cmd_write;
        set_cmd = wr && (cmd_code == `RSS_CMD_SET_TARGET);
        clr_fault = wr && (cmd_code == `RSS_CMD_CLEAR_FAULT);
        start_ok = por_s && en_s && tm_s && !ocp_s && !st_reg.off_latched;
        sat = (current_monitor_code >= `RSS_CURRENT_MONITOR_OUT_SAT_CODE);

        // Target command: off code latches a hold in shutdown
        if (set_cmd)
        begin
            st_next.target = cmd_wdata[7:0];
            st_next.off_latched = (cmd_wdata[7:0] == `RSS_TARGET_OFF);
            st_next.tgt_new = (cmd_wdata[7:0] != `RSS_TARGET_OFF);
        end

        // Configuration writes
        if (wr && (cmd_code == `RSS_CMD_IOUT_OFS))
            st_next.ofs_a = cmd_wdata;
        if (wr && (cmd_code == `RSS_CMD_CAL_OFS))
            st_next.ofs_b = cmd_wdata;
        if (wr && (cmd_code == `RSS_CMD_MAX_CURRENT))
            st_next.maxcur = cmd_wdata;
        if (wr && (cmd_code == `RSS_CMD_SLEW))
            st_next.slew = cmd_wdata[4:0];

        // Current sampling, saturation and offsets
        if (sat)
            raw_iout = st_reg.maxcur;
        else
            raw_iout = {6'h00, current_monitor_code};
        if (st_reg.smp_cnt >= 12'(`RSS_SAMPLE_CYC - 1))
        begin
            st_next.smp_cnt = '0;
            st_next.iout = raw_iout + st_reg.ofs_a + st_reg.ofs_b;
        end
        else
            st_next.smp_cnt = st_reg.smp_cnt + 12'h001;

        // Sticky status: set wins over clear-fault
        st_set = '0;
        st_set[`RSS_ST_TEMP] = talert_s;
        st_set[`RSS_ST_IOUT_WARN] = sat;
        st_set[`RSS_ST_IOUT_OC] = ocp_s;
        st_set[`RSS_ST_OFF] = (st_reg.state == RSS_SHUTDOWN) && por_s &&
            st_reg.off_latched;
        if (clr_fault)
            st_next.status = st_set;
        else
            st_next.status = st_reg.status | st_set;
        st_next.alert_oe = (st_next.status != 8'h00);

        // Sequencer
        st_next.cnt = st_reg.cnt + 19'h00001;
        unique case (st_reg.state)
            RSS_SHUTDOWN:
            begin
                st_next.cnt = '0;
                if (start_ok)
                    st_next.state = RSS_CFG_LOAD;
            end
            RSS_CFG_LOAD:
            begin
                if (bank_s || (st_reg.cnt >= CFG_LOAD_CYCLES - 19'h00001))
                begin
                    st_next.state = RSS_FIXED_DELAY;
                    st_next.cnt = '0;
                end
            end
            RSS_FIXED_DELAY:
            begin
                if (st_reg.cnt >= 19'(`RSS_TD1_CYC - 1))
                    st_next.state = RSS_BOOT_RAMP;
            end
            RSS_BOOT_RAMP:
            begin
                if (st_reg.tgt_new)
                begin
                    st_next.state = RSS_TARGET_RAMP;
                    st_next.tgt_new = set_cmd;
                end
                else if (dac_now == boot_voltage_setting)
                    st_next.state = RSS_BOOT_HOLD;
            end
            RSS_BOOT_HOLD:
            begin
                if (st_reg.tgt_new)
                begin
                    st_next.state = RSS_TARGET_RAMP;
                    st_next.tgt_new = set_cmd;
                end
            end
            RSS_TARGET_RAMP:
            begin
                st_next.tgt_new = set_cmd && st_next.tgt_new;
                if ((dac_now == st_reg.target) && !st_reg.tgt_new)
                    st_next.state = RSS_REGULATE;
            end
            RSS_REGULATE:
            begin
                if (st_reg.tgt_new)
                begin
                    st_next.state = RSS_TARGET_RAMP;
                    st_next.tgt_new = set_cmd;
                end
            end
            default:
                st_next.state = RSS_SHUTDOWN;
        endcase
        if (!start_ok)
        begin
            st_next.state = RSS_SHUTDOWN;
            st_next.cnt = '0;
        end

        // Pin outputs
        st_next.pwm_hiz = (st_next.state == RSS_SHUTDOWN);
        st_next.ready = (st_next.state == RSS_REGULATE) && win_s;

        // Read answer, one cycle after the request
        st_next.rvalid = rd;
        st_next.rdata = '0;
        if (rd)
        begin
            unique case (cmd_code)
                `RSS_CMD_STATUS: st_next.rdata = {8'h00, st_reg.status};
                `RSS_CMD_IOUT: st_next.rdata = st_reg.iout;
                `RSS_CMD_IOUT_OFS: st_next.rdata = st_reg.ofs_a;
                `RSS_CMD_CAL_OFS: st_next.rdata = st_reg.ofs_b;
                `RSS_CMD_MAX_CURRENT: st_next.rdata = st_reg.maxcur;
                `RSS_CMD_SLEW: st_next.rdata = {11'h000, st_reg.slew};
                `RSS_CMD_SET_TARGET: st_next.rdata = {8'h00, st_reg.target};
                default: st_next.rdata = '0;
            endcase
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
            st_reg.state <= RSS_SHUTDOWN;
            st_reg.slew <= `RSS_SLEW_RST;
            st_reg.maxcur <= `RSS_MAXCUR_RST;
            st_reg.pwm_hiz <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign cmd_rdata = st_reg.rdata;
    assign cmd_rvalid = st_reg.rvalid;
    assign host_alert_n_out = 1'b0; // Open drain only ever pulls low
    assign host_alert_n_oe = st_reg.alert_oe;
    assign pwm_hiz = st_reg.pwm_hiz;
    assign dac_code = dac_now;
    assign regulator_ready = st_reg.ready;

endmodule // rss_sequencer

/* File: common/rss_cfg.svh */
/*
 * Constants of the regulator start-up sequencer: command codes, status
 * bits, reset values and timing figures.
 * Assumes a 25 MHz ref_clk; included by bare name.
 */
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define RSS_CMD_CLEAR_FAULT 8'h03
`define RSS_CMD_MAX_CURRENT 8'h21
`define RSS_CMD_STATUS 8'h78
`define RSS_CMD_IOUT 8'h8C
`define RSS_CMD_SET_TARGET 8'hD0
`define RSS_CMD_IOUT_OFS 8'hE4
`define RSS_CMD_CAL_OFS 8'hE5
`define RSS_CMD_SLEW 8'hF6

// ----------------------------------------------------------------------
// Status bits, codes and reset values
// ----------------------------------------------------------------------
`define RSS_ST_TEMP 2
`define RSS_ST_IOUT_WARN 5
`define RSS_ST_IOUT_OC 4
`define RSS_ST_OFF 6
`define RSS_TARGET_OFF 8'h00
`define RSS_CURRENT_MONITOR_OUT_SAT_CODE 10'h300
`define RSS_SLEW_RST 5'h0A
`define RSS_MAXCUR_RST 16'h00FF

// ----------------------------------------------------------------------
// Timing: figures in their own unit, counts derived
// ----------------------------------------------------------------------
`define RSS_CLK_NS 40
`define RSS_TD1_NS 20000
`define RSS_TD1_CYC (`RSS_TD1_NS / `RSS_CLK_NS)
`define RSS_CFG_LOAD_MS 20
`define RSS_CFG_LOAD_CYC (`RSS_CFG_LOAD_MS * 1000000 / `RSS_CLK_NS)
`define RSS_SAMPLE_NS 88000
`define RSS_SAMPLE_CYC (`RSS_SAMPLE_NS / `RSS_CLK_NS)
`define RSS_DAC_STEP_UV 5000
// Slew options in uV per us
`define RSS_SLEW_0 315
`define RSS_SLEW_1 625
`define RSS_SLEW_2 1250
`define RSS_SLEW_3 2500
`define RSS_SLEW_4 2850
`define RSS_SLEW_5 3070
`define RSS_SLEW_6 3330
`define RSS_SLEW_7 3630
`define RSS_SLEW_8 4000
`define RSS_SLEW_9 4440
`define RSS_SLEW_A 5000
`define RSS_SLEW_B 5600
`define RSS_SLEW_C 6660
`define RSS_SLEW_D 8000
`define RSS_SLEW_E 10000
`define RSS_SLEW_F 13250
// Cycles per 5 mV step, rounded down
`define RSS_STEP_CYC(r) (`RSS_DAC_STEP_UV * 1000 / ((r) * `RSS_CLK_NS))

`endif

/* File: common/rss_pkg.sv */
/*
 * Types of the regulator start-up sequencer.
 * Assumes nothing beyond the compiler.
 */
package rss_pkg;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        RSS_SHUTDOWN = 3'b000,
        RSS_CFG_LOAD = 3'b001,
        RSS_FIXED_DELAY = 3'b010,
        RSS_BOOT_RAMP = 3'b011,
        RSS_BOOT_HOLD = 3'b100,
        RSS_TARGET_RAMP = 3'b101,
        RSS_REGULATE = 3'b110
    } rss_state_e;

    // ------------------------------------------------------------------
    // Module state records
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] dac;
        logic [8:0] cnt;
    } rss_ramp_s;

    typedef struct packed {
        rss_state_e state;
        logic [18:0] cnt;
        logic [11:0] smp_cnt;
        logic [7:0] target;
        logic tgt_new;
        logic off_latched;
        logic [7:0] status;
        logic [15:0] iout;
        logic [15:0] ofs_a;
        logic [15:0] ofs_b;
        logic [15:0] maxcur;
        logic [4:0] slew;
        logic [15:0] rdata;
        logic rvalid;
        logic ready;
        logic pwm_hiz;
        logic alert_oe;
    } rss_top_s;

endpackage

/* File: verilog/rss_sync.sv */
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes asynchronous inputs; only the second stage is read outside.
 */
`timescale 1ns/1ps
module rss_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } rss_sync_s;

    rss_sync_s st_reg;
    rss_sync_s st_next;

    // Shift through both stages
    always_comb
    begin
        st_next.s1 = pin_in;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign pin_sync = st_reg.s2;

endmodule // rss_sync

/* File: verilog/rss_ramp.sv */
/*
 * Reference DAC stepper: moves one 5 mV code per step period toward
 * the requested target.
 * Assumes step_cycles is at least one and the caller clears run in
 * shutdown.
 */
`timescale 1ns/1ps
module rss_ramp
    import rss_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ramp_run,
    input wire logic [7:0] ramp_target,
    input wire logic [8:0] step_cycles,
    output logic [7:0] dac_code
);

    rss_ramp_s st_reg;
    rss_ramp_s st_next;

    // Step pacing and direction; target may move at any time
    always_comb
    begin
        st_next = st_reg;
        if (!ramp_run)
            st_next = '0;
        else if (st_reg.dac == ramp_target)
            st_next.cnt = '0;
        else if (st_reg.cnt >= step_cycles - 9'h001)
        begin
            st_next.cnt = '0;
            if (st_reg.dac < ramp_target)
                st_next.dac = st_reg.dac + 8'h01;
            else
                st_next.dac = st_reg.dac - 8'h01;
        end
        else
            st_next.cnt = st_reg.cnt + 9'h001;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign dac_code = st_reg.dac;

endmodule // rss_ramp

/* File: bench/rss_sequencer_sva.sv */
/* Port checker of the start-up sequencer.
   Assumes a bind to rss_sequencer and one clock domain. */
`timescale 1ns/1ps
module rss_sequencer_sva (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic power_sequence_enable,
    input wire logic thermal_monitor_enable,
    input wire logic thermal_alert,
    input wire logic output_in_window,
    input wire logic current_monitor_out_over_ocp,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic cmd_rvalid,
    input wire logic host_alert_n_oe,
    input wire logic pwm_hiz,
    input wire logic [7:0] dac_code,
    input wire logic regulator_ready
);
    logic [11:0] run_cnt;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Cycles since leaving shutdown, saturating
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            run_cnt <= 12'h000;
        else if (pwm_hiz)
            run_cnt <= 12'h000;
        else if (run_cnt != 12'hFFF)
            run_cnt <= run_cnt + 12'h001;
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_enable_gate: assert property (!power_sequence_enable [*5] |-> pwm_hiz)
        else $error("enable low but not shut down");
    a_thermal_gate: assert property (!thermal_monitor_enable [*5] |-> pwm_hiz)
        else $error("thermal enable low but not shut down");
    a_ocp_shutdown: assert property (current_monitor_out_over_ocp [*5] |-> pwm_hiz)
        else $error("overcurrent without shutdown");
    a_alert_raise: assert property (thermal_alert [*5] |-> host_alert_n_oe)
        else $error("thermal alert not on alert line");
    a_read_answer: assert property (cmd_rvalid == $past(cmd_valid && !cmd_write))
        else $error("read answer timing wrong");
    a_dac_step: assert property ($changed(dac_code) && !pwm_hiz |->
        dac_code == $past(dac_code) + 8'h01 || dac_code == $past(dac_code) - 8'h01)
        else $error("dac moved more than one code");
    a_dac_rest: assert property (pwm_hiz && $past(pwm_hiz) |-> dac_code == 8'h00)
        else $error("dac not parked in shutdown");
    a_hiz_ready: assert property (pwm_hiz |-> !regulator_ready)
        else $error("ready while shut down");
    a_window_ready: assert property (!output_in_window [*5] |-> !regulator_ready)
        else $error("ready outside window");
    a_fixed_delay: assert property ($past(dac_code) == 8'h00 && dac_code != 8'h00 |->
        run_cnt >= 12'h1F4)
        else $error("ramp began before fixed delay");
    c_ready: cover property ($rose(regulator_ready));
    c_read: cover property (cmd_rvalid);
    c_alert: cover property ($rose(host_alert_n_oe));
endmodule // rss_sequencer_sva

bind rss_sequencer rss_sequencer_sva rss_sequencer_sva_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .power_sequence_enable(power_sequence_enable),
    .thermal_monitor_enable(thermal_monitor_enable), .thermal_alert(thermal_alert),
    .output_in_window(output_in_window), .current_monitor_out_over_ocp(current_monitor_out_over_ocp),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_rvalid(cmd_rvalid),
    .host_alert_n_oe(host_alert_n_oe), .pwm_hiz(pwm_hiz), .dac_code(dac_code),
    .regulator_ready(regulator_ready)
);

/* File: bench/rss_far_side.sv */
/* Far side model: phase drivers and the pulled-up alert wire.
   Assumes an open-drain alert driver and a pull-up on the wire. */
`timescale 1ns/1ps
module rss_far_side (
    input wire logic pwm_hiz,
    input wire logic host_alert_n_out,
    input wire logic host_alert_n_oe,
    output logic alert_line,
    output logic drivers_off
);
    // Pull-up wins unless the controller pulls low
    assign alert_line = host_alert_n_oe ? host_alert_n_out : 1'b1;
    // Drivers turn both switches off on a floating input
    assign drivers_off = pwm_hiz;
endmodule // rss_far_side

/* File: bench/tb.sv */
/* Testbench: register rows, start-up, ramps, current report, shutdowns.
   Assumes the bound checker and a shortened bank load count. */
`timescale 1ns/1ps
`include "rss_cfg.svh"
module tb;
    typedef struct {logic w; logic [7:0] c; logic [15:0] d; logic [15:0] e;} rss_row_s;
    logic ref_clk = 1'b0, rst_n = 1'b0, por = 1'b1, en = 1'b0, tm = 1'b1, talert = 1'b0;
    logic bank = 1'b0, win = 1'b0, ocp = 1'b0, cv = 1'b0, cw = 1'b0;
    logic rv, a_out, a_oe, hiz, rdy, alert_line, drv_off;
    logic [9:0] current_monitor_out = 10'h000;
    logic [7:0] boot = 8'h08, cc = 8'h00, dac, top;
    logic [15:0] wd = 16'h0000, rd, r;
    int n_mismatch = 0, samples_checked = 0, cycles = 0, t;
    rss_row_s rows [13] = '{
        '{1'b0, 8'hF6, 16'h0000, 16'h000A}, '{1'b0, 8'h21, 16'h0000, 16'h00FF},
        '{1'b0, 8'h78, 16'h0000, 16'h0000}, '{1'b0, 8'h03, 16'h0000, 16'h0000},
        '{1'b0, 8'h55, 16'h0000, 16'h0000}, '{1'b1, 8'hE4, 16'h1234, 16'h0000},
        '{1'b0, 8'hE4, 16'h0000, 16'h1234}, '{1'b1, 8'hE5, 16'h0010, 16'h0000},
        '{1'b0, 8'hE5, 16'h0000, 16'h0010}, '{1'b1, 8'h21, 16'h0200, 16'h0000},
        '{1'b0, 8'h21, 16'h0000, 16'h0200}, '{1'b1, 8'hF6, 16'h000F, 16'h0000},
        '{1'b0, 8'hF6, 16'h0000, 16'h000F}};

    rss_sequencer #(.CFG_LOAD_CYCLES(19'h00032)) rss_sequencer_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .supply_por_ok(por),
        .power_sequence_enable(en), .thermal_monitor_enable(tm), .thermal_alert(talert),
        .configuration_bank_loaded(bank), .output_in_window(win), .current_monitor_out_over_ocp(ocp),
        .current_monitor_code(current_monitor_out), .boot_voltage_setting(boot), .cmd_valid(cv),
        .cmd_write(cw), .cmd_code(cc), .cmd_wdata(wd), .cmd_rdata(rd), .cmd_rvalid(rv),
        .host_alert_n_in(alert_line), .host_alert_n_out(a_out), .host_alert_n_oe(a_oe),
        .pwm_hiz(hiz), .dac_code(dac), .regulator_ready(rdy));
    rss_far_side rss_far_side_i (.pwm_hiz(hiz), .host_alert_n_out(a_out),
        .host_alert_n_oe(a_oe), .alert_line(alert_line), .drivers_off(drv_off));

    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end
    // Cuts a hang short
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
        cv = 1'b1;
        cw = w;
        cc = c;
        wd = d;
        cyc(1);
        r = rd;
        if (!w) chk("read answer", {15'h0000, rv}, 16'h0001);
        cv = 1'b0;
        cyc(1);
    endtask
    task automatic wait_dac(input logic [7:0] v);
        for (t = 0; t < 3000 && dac !== v; t++) cyc(1);
    endtask
    task automatic step_len(input int exp);
        wait_dac(8'h01);
        for (t = 0; t < 200 && dac !== 8'h02; t++) cyc(1);
        chk("step cycles", 16'(t), 16'(exp));
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        cyc(3);
        chk("reset outputs", {hiz, rdy, a_oe, rv, dac}, 16'h0800);
        rst_n = 1'b1;
        cyc(1);
        foreach (rows[k])
        begin
            cmd(rows[k].w, rows[k].c, rows[k].d);
            if (!rows[k].w) chk("register", r, rows[k].e);
        end
        $display("test registers done");
        talert = 1'b1;
        cyc(5);
        talert = 1'b0;
        chk("alert line", {15'h0000, alert_line}, 16'h0000);
        cmd(1'b0, `RSS_CMD_STATUS, 16'h0000);
        chk("thermal status", r, 16'h0004);
        cmd(1'b1, `RSS_CMD_CLEAR_FAULT, 16'h0000);
        cmd(1'b0, `RSS_CMD_STATUS, 16'h0000);
        chk("cleared status", r, 16'h0000);
        chk("alert released", {alert_line, drv_off}, 16'h0003);
        $display("test thermal clear done");
        en = 1'b1;
        for (t = 0; t < 20 && hiz !== 1'b0; t++) cyc(1);
        for (t = 0; t < 2000 && dac === 8'h00; t++) cyc(1);
        chk("start delay", 16'(t >= 550), 16'h0001);
        step_len(5000000 / (`RSS_SLEW_F * 40));
        wait_dac(boot);
        cyc(30);
        chk("boot hold", {rdy, 7'h00, dac}, {8'h00, boot});
        cmd(1'b1, `RSS_CMD_SET_TARGET, 16'h000C);
        wait_dac(8'h0C);
        win = 1'b1;
        cyc(5);
        chk("ready", {15'h0000, rdy}, 16'h0001);
        win = 1'b0;
        cyc(5);
        chk("ready window", {15'h0000, rdy}, 16'h0000);
        $display("test start-up done");
        current_monitor_out = 10'h100;
        cyc(2300);
        cmd(1'b0, `RSS_CMD_IOUT, 16'h0000);
        chk("current", r, 16'h1344);
        current_monitor_out = 10'h3FF;
        cyc(2300);
        cmd(1'b0, `RSS_CMD_IOUT, 16'h0000);
        chk("saturated current", r, 16'h1444);
        chk("saturation alert", {15'h0000, alert_line}, 16'h0000);
        current_monitor_out = 10'h000;
        cmd(1'b0, `RSS_CMD_STATUS, 16'h0000);
        chk("warn status", r, 16'h0020);
        cmd(1'b1, `RSS_CMD_CLEAR_FAULT, 16'h0000);
        $display("test current done");
        ocp = 1'b1;
        cyc(5);
        chk("ocp shutdown", {hiz, rdy, 6'h00, dac}, 16'h8000);
        cmd(1'b1, `RSS_CMD_SET_TARGET, 16'h0000);
        ocp = 1'b0;
        cyc(10);
        chk("off code", {15'h0000, hiz}, 16'h0001);
        cmd(1'b0, `RSS_CMD_STATUS, 16'h0000);
        chk("ocp off status", r, 16'h0050);
        cmd(1'b1, `RSS_CMD_CLEAR_FAULT, 16'h0000);
        $display("test shutdown done");
        cmd(1'b1, `RSS_CMD_SLEW, 16'h0003);
        bank = 1'b1;
        cmd(1'b1, `RSS_CMD_SET_TARGET, 16'h000C);
        step_len(5000000 / (`RSS_SLEW_3 * 40));
        cmd(1'b1, `RSS_CMD_SET_TARGET, 16'h0005);
        top = 8'h00;
        for (t = 0; t < 600; t++)
        begin
            cyc(1);
            if (dac > top) top = dac;
        end
        chk("redirect", {top, dac}, 16'h0505);
        tm = 1'b0;
        cyc(5);
        chk("thermal enable off", {15'h0000, hiz}, 16'h0001);
        tm = 1'b1;
        for (t = 0; t < 20 && hiz !== 1'b0; t++) cyc(1);
        chk("restart", {15'h0000, hiz}, 16'h0000);
        por = 1'b0;
        cyc(5);
        chk("supply off", {15'h0000, hiz}, 16'h0001);
        $display("test redirect done");
        // Reset in mid-run returns outputs and settings to reset values
        rst_n = 1'b0;
        cyc(2);
        chk("mid reset", {hiz, rdy, a_oe, rv, dac}, 16'h0800);
        rst_n = 1'b1;
        cyc(1);
        cmd(1'b0, `RSS_CMD_SLEW, 16'h0000);
        chk("slew reset", r, 16'h000A);
        $display("test reset done");
        tally_and_finish();
    end
endmodule // tb
